// File: usbepm_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Sixteen endpoints: control pair plus fourteen
// - All PIO; DMA only endpoints 2 to 15
// - DMA goes to index field, gated by enable
// - Max packet equals configured buffer size
// - Disabled endpoints get zero storage
// - Allocation from enable, size code, iso bit
// - Non-iso codes 0 to 3 give 8 to 64 bytes
// - Iso codes give 16 to 1023 bytes
// - Double buffer doubles physical storage on endpoints 2 to 15
// - Allocation follows config writes automatically
// - Resets disable and clear configurable endpoints
// - Packet sent or received sets event bit
// - Status read clears event, reports buffer state
// - Receive: read, clear, then accept next
// - Transmit: write, validate, then send
// - Set-up flushes IN, blocks clear and validate
// - Acknowledge set-up on both re-enables commands
// - IN token sends validated data else NAK
// - OUT token stores if room and length within max packet else NAK
module usbepm_top (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_usb_reset,
  input wire usbepm_pkg::usbepm_wbreq_s i_wb,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire usbepm_pkg::usbepm_tok_s i_tok,
  output usbepm_pkg::usbepm_rsp_s o_rsp,
  output logic [15:0] o_ep_events,
  output logic [3:0] o_dma_ep,
  output logic o_dma_active,
  output logic o_dma_write
);

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  typedef struct packed {
    logic [15:0][7:0] cfg;
    logic [4:0] dma;
    logic [15:0] evt;
    logic [15:0][1:0] cnt;
    logic [1:0] lock;
    logic ack;
    logic [31:0] dat;
    usbepm_pkg::usbepm_rsp_s rsp;
    logic dma_act;
    logic dma_wr;
  } usbepm_st_s;

  usbepm_st_s st_ff;
  usbepm_st_s nxt_st;
  usbepm_st_s rst_st;

  logic [15:0][10:0] lsz;
  logic [15:0][11:0] phys;
  logic [15:0][1:0] cap;
  logic [15:0] ep_en;
  logic [15:0] ep_dir;
  logic [14:0] total;

  // ---------------------------------------------
  // Allocation per endpoint
  // ---------------------------------------------
  for (genvar i = 0; i < 16; i++)
  begin : g_ep
    logic [3:0] code;
    logic iso;
    logic dbl;
    assign code = st_ff.cfg[i][3:0];
    assign iso = st_ff.cfg[i][usbepm_pkg::CFG_ISO];
    assign dbl = st_ff.cfg[i][usbepm_pkg::CFG_DBL] && (i >= 2);
    assign ep_en[i] = st_ff.cfg[i][usbepm_pkg::CFG_EN];
    assign ep_dir[i] = st_ff.cfg[i][usbepm_pkg::CFG_DIR];
    always_comb
    begin
      if (!ep_en[i])
      begin
        lsz[i] = 11'h000;
      end
      else if (iso)
      begin
        lsz[i] = usbepm_pkg::ISO_SIZE[code];
      end
      else if (code[3:2] == 2'h0)
      begin
        lsz[i] = usbepm_pkg::NISO_SIZE[code[1:0]];
      end
      else
      begin
        lsz[i] = 11'h000;
      end
    end
    assign phys[i] = dbl ? {lsz[i], 1'b0} : {1'b0, lsz[i]};
    assign cap[i] = (lsz[i] == 11'h000) ? 2'h0 : (dbl ? 2'h2 : 2'h1);
  end

  always_comb
  begin
    total = 15'h0000;
    for (int i = 0; i < 16; i++)
    begin
      total = total + {3'h0, phys[i]};
    end
  end

  // ---------------------------------------------
  // Reset image
  // ---------------------------------------------
  always_comb
  begin
    rst_st = '0;
    for (int i = 0; i < 16; i++)
    begin
      rst_st.cfg[i] = usbepm_pkg::CFG_RST;
    end
    rst_st.cfg[usbepm_pkg::EP_CTRL_OUT] = usbepm_pkg::CFG_CTRL_OUT;
    rst_st.cfg[usbepm_pkg::EP_CTRL_IN] = usbepm_pkg::CFG_CTRL_IN;
    rst_st.dma = usbepm_pkg::DMA_RST;
  end

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic [3:0] wi;
  logic [3:0] ce;
  usbepm_pkg::usbepm_cmd_e op;
  logic blocked;
  logic [15:0] evt_set;
  logic [15:0] evt_clr;
  logic [31:0] rdat;
  logic [3:0] te;

  always_comb
  begin
    nxt_st = st_ff;
    evt_set = 16'h0000;
    evt_clr = 16'h0000;
    req = i_wb.cyc && i_wb.stb && !st_ff.ack;
    wr = req && i_wb.we;
    rd = req && !i_wb.we;
    wi = i_wb.adr[5:2];
    ce = i_wb.dat[3:0];
    op = usbepm_pkg::usbepm_cmd_e'(i_wb.dat[6:4]);
    blocked = (ce < usbepm_pkg::EP_FIRST_CFG) && (st_ff.lock != 2'h0);
    te = i_tok.ep;
    nxt_st.ack = req;
    nxt_st.rsp.send = 1'b0;
    nxt_st.rsp.store = 1'b0;
    nxt_st.rsp.nak = 1'b0;
    nxt_st.rsp.maxpkt = lsz[te];
    // Read data
    rdat = 32'h0000_0000;
    if (i_wb.adr[7:6] == 2'h0)
    begin
      rdat = {24'h00_0000, st_ff.cfg[wi]};
    end
    else if (i_wb.adr[7:6] == 2'h1)
    begin
      rdat = {27'h000_0000, st_ff.cfg[wi][usbepm_pkg::CFG_DBL],
        (wi < usbepm_pkg::EP_FIRST_CFG) && (st_ff.lock != 2'h0),
        st_ff.cnt[wi], st_ff.evt[wi]};
    end
    else if (i_wb.adr == usbepm_pkg::ADR_IRQ)
    begin
      rdat = {16'h0000, st_ff.evt};
    end
    else if (i_wb.adr == usbepm_pkg::ADR_DMA)
    begin
      rdat = {27'h000_0000, st_ff.dma};
    end
    else if (i_wb.adr == usbepm_pkg::ADR_ALLOC)
    begin
      rdat = {16'h0000, total > usbepm_pkg::PHYS_LIMIT, total};
    end
    if (req)
    begin
      nxt_st.dat = rdat;
    end
    // Register writes
    if (wr && i_wb.sel[0] && (i_wb.adr[7:6] == 2'h0) && (wi >= usbepm_pkg::EP_FIRST_CFG))
    begin
      nxt_st.cfg[wi] = i_wb.dat[7:0];
    end
    if (wr && i_wb.sel[0] && (i_wb.adr == usbepm_pkg::ADR_DMA))
    begin
      nxt_st.dma = i_wb.dat[4:0];
    end
    if (rd && (i_wb.adr[7:6] == 2'h1))
    begin
      evt_clr[wi] = 1'b1;
    end
    // Firmware commands
    if (wr && i_wb.sel[0] && (i_wb.adr == usbepm_pkg::ADR_CMD))
    begin
      case (op)
        usbepm_pkg::CMD_CLEAR:
        begin
          if (!blocked && !ep_dir[ce] && (st_ff.cnt[ce] != 2'h0))
          begin
            nxt_st.cnt[ce] = st_ff.cnt[ce] - 2'h1;
          end
        end
        usbepm_pkg::CMD_VALID:
        begin
          if (!blocked && ep_dir[ce] && (st_ff.cnt[ce] < cap[ce]))
          begin
            nxt_st.cnt[ce] = st_ff.cnt[ce] + 2'h1;
          end
        end
        usbepm_pkg::CMD_ACKSU:
        begin
          if (ce < usbepm_pkg::EP_FIRST_CFG)
          begin
            nxt_st.lock[ce[0]] = 1'b0;
          end
        end
        default:
        begin
          nxt_st.lock = nxt_st.lock;
        end
      endcase
    end
    // Serial engine tokens
    if (i_tok.vld)
    begin
      case (i_tok.kind)
        usbepm_pkg::TOK_IN:
        begin
          if (ep_en[te] && ep_dir[te] && (nxt_st.cnt[te] != 2'h0))
          begin
            nxt_st.cnt[te] = nxt_st.cnt[te] - 2'h1;
            nxt_st.rsp.send = 1'b1;
            evt_set[te] = 1'b1;
          end
          else
          begin
            nxt_st.rsp.nak = 1'b1;
          end
        end
        usbepm_pkg::TOK_OUT:
        begin
          if (ep_en[te] && !ep_dir[te] && (nxt_st.cnt[te] < cap[te]) && (i_tok.len <= lsz[te]))
          begin
            nxt_st.cnt[te] = nxt_st.cnt[te] + 2'h1;
            nxt_st.rsp.store = 1'b1;
            evt_set[te] = 1'b1;
          end
          else
          begin
            nxt_st.rsp.nak = 1'b1;
          end
        end
        usbepm_pkg::TOK_SETUP:
        begin
          if (te == usbepm_pkg::EP_CTRL_OUT)
          begin
            nxt_st.cnt[usbepm_pkg::EP_CTRL_OUT] = 2'h1;
            nxt_st.cnt[usbepm_pkg::EP_CTRL_IN] = 2'h0;
            nxt_st.lock = 2'h3;
            nxt_st.rsp.store = 1'b1;
            evt_set[usbepm_pkg::EP_CTRL_OUT] = 1'b1;
          end
          else
          begin
            nxt_st.rsp.nak = 1'b1;
          end
        end
        default:
        begin
          nxt_st.rsp.nak = 1'b1;
        end
      endcase
    end
    // Event bits, set wins over clear
    nxt_st.evt = (st_ff.evt & ~evt_clr) | evt_set;
    // Bus reset
    if (i_usb_reset)
    begin
      nxt_st.cfg = rst_st.cfg;
      nxt_st.dma = rst_st.dma;
      nxt_st.evt = 16'h0000;
      nxt_st.cnt = '0;
      nxt_st.lock = 2'h0;
      nxt_st.rsp.send = 1'b0;
      nxt_st.rsp.store = 1'b0;
      nxt_st.rsp.nak = 1'b0;
    end
    // DMA target
    nxt_st.dma_act = nxt_st.dma[usbepm_pkg::DMA_EN] && (nxt_st.dma[3:0] >= usbepm_pkg::EP_FIRST_CFG)
      && ep_en[nxt_st.dma[3:0]];
    nxt_st.dma_wr = ep_dir[nxt_st.dma[3:0]];
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_ff.cfg <= {usbepm_pkg::CFG_CTRL_IN, usbepm_pkg::CFG_CTRL_OUT} |
        128'h0000_0000_0000_0000_0000_0000_0000_0000;
      st_ff.dma <= usbepm_pkg::DMA_RST;
      st_ff.evt <= 16'h0000;
      st_ff.cnt <= 32'h0000_0000;
      st_ff.lock <= 2'h0;
      st_ff.ack <= 1'b0;
      st_ff.dat <= 32'h0000_0000;
      st_ff.rsp <= 14'h0000;
      st_ff.dma_act <= 1'b0;
      st_ff.dma_wr <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign o_wb_ack = st_ff.ack;
  assign o_wb_dat = st_ff.dat;
  assign o_rsp = st_ff.rsp;
  assign o_ep_events = st_ff.evt;
  assign o_dma_ep = st_ff.dma[3:0];
  assign o_dma_active = st_ff.dma_act;
  assign o_dma_write = st_ff.dma_wr;

endmodule
`default_nettype wire

// File: usbepm_pkg.sv
package usbepm_pkg;
  // ---------------------------------------------
  // Register offsets
  // ---------------------------------------------
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h40;
  localparam logic [7:0] ADR_IRQ = 8'h80;
  localparam logic [7:0] ADR_DMA = 8'h84;
  localparam logic [7:0] ADR_CMD = 8'h88;
  localparam logic [7:0] ADR_ALLOC = 8'h8C;
  // ---------------------------------------------
  // Field positions
  // ---------------------------------------------
  localparam int CFG_ISO = 4;
  localparam int CFG_DIR = 5;
  localparam int CFG_DBL = 6;
  localparam int CFG_EN = 7;
  localparam int DMA_EN = 4;
  localparam int ALLOC_OVER = 15;
  // ---------------------------------------------
  // Reset values and fixed codes
  // ---------------------------------------------
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CFG_CTRL_OUT = 8'h83;
  localparam logic [7:0] CFG_CTRL_IN = 8'hA3;
  localparam logic [4:0] DMA_RST = 5'h00;
  localparam logic [3:0] EP_CTRL_OUT = 4'h0;
  localparam logic [3:0] EP_CTRL_IN = 4'h1;
  localparam logic [3:0] EP_FIRST_CFG = 4'h2;
  localparam logic [14:0] PHYS_LIMIT = 15'h099E;
  // ---------------------------------------------
  // Buffer size tables
  // ---------------------------------------------
  localparam logic [3:0][10:0] NISO_SIZE = {11'h040, 11'h020, 11'h010, 11'h008};
  localparam logic [15:0][10:0] ISO_SIZE = {
    11'h3FF, 11'h380, 11'h300, 11'h280, 11'h200, 11'h180, 11'h140, 11'h100,
    11'h0C0, 11'h0A0, 11'h080, 11'h060, 11'h040, 11'h030, 11'h020, 11'h010};
  // ---------------------------------------------
  // Types
  // ---------------------------------------------
  typedef enum logic [2:0] {CMD_NONE, CMD_CLEAR, CMD_VALID, CMD_ACKSU} usbepm_cmd_e;
  typedef enum logic [1:0] {TOK_IN, TOK_OUT, TOK_SETUP} usbepm_tok_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } usbepm_wbreq_s;
  typedef struct packed {
    logic vld;
    usbepm_tok_e kind;
    logic [3:0] ep;
    logic [10:0] len;
  } usbepm_tok_s;
  typedef struct packed {
    logic send;
    logic store;
    logic nak;
    logic [10:0] maxpkt;
  } usbepm_rsp_s;
endpackage

// File: usbepm_props.sv
`timescale 1ns/100ps
`default_nettype none
module usbepm_props (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_usb_reset,
  input wire usbepm_pkg::usbepm_wbreq_s i_wb,
  input wire logic o_wb_ack,
  input wire usbepm_pkg::usbepm_tok_s i_tok,
  input wire usbepm_pkg::usbepm_rsp_s o_rsp,
  input wire logic [15:0] o_ep_events,
  input wire logic [3:0] o_dma_ep,
  input wire logic o_dma_active
);
  // ----
  // Sequences
  // ----
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_wb_req;
    i_wb.cyc && i_wb.stb && !o_wb_ack;
  endsequence
  sequence s_rsp;
    o_rsp.send || o_rsp.store || o_rsp.nak;
  endsequence
  // ----
  // Properties
  // ----
  a_ack_exact: assert property (s_wb_req |=> o_wb_ack)
    else $error("bus ack late");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("bus ack too long");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb.stb))
    else $error("bus ack without request");
  a_tok_answer: assert property (i_tok.vld && i_tok.kind != usbepm_pkg::TOK_SETUP && !i_usb_reset |=> s_rsp)
    else $error("token unanswered");
  a_rsp_cause: assert property (s_rsp |-> $past(i_tok.vld))
    else $error("answer without token");
  a_rsp_single: assert property ($onehot0({o_rsp.send, o_rsp.store, o_rsp.nak}))
    else $error("answer not single");
  a_send_event: assert property (o_rsp.send |-> $past(i_tok.kind) == usbepm_pkg::TOK_IN && o_ep_events[$past(i_tok.ep)])
    else $error("send without event");
  a_store_event: assert property (o_rsp.store |-> ($past(i_tok.kind) == usbepm_pkg::TOK_OUT ||
    $past(i_tok.kind) == usbepm_pkg::TOK_SETUP) && o_ep_events[$past(i_tok.ep)])
    else $error("store without event");
  a_dma_range: assert property (o_dma_active |-> o_dma_ep >= 4'h2)
    else $error("dma on control endpoint");
  a_bus_reset: assert property (i_usb_reset && !i_tok.vld |=> o_ep_events == 16'h0000 && !o_dma_active)
    else $error("bus reset left state");
endmodule
bind usbepm_top usbepm_props u_props (.i_mclk, .i_resetn, .i_usb_reset, .i_wb, .o_wb_ack, .i_tok, .o_rsp,
  .o_ep_events, .o_dma_ep, .o_dma_active);
`default_nettype wire

// File: usbepm_host.sv
`timescale 1ns/100ps
`default_nettype none
module usbepm_host (
  input wire logic i_mclk,
  output usbepm_pkg::usbepm_tok_s o_tok
);
  // ----
  // Token issue, idle on endpoint index 2
  // ----
  initial o_tok = '{vld: 1'b0, kind: usbepm_pkg::TOK_IN, ep: 4'h2, len: 11'h000};
  task automatic send_tok(input usbepm_pkg::usbepm_tok_e k, input logic [3:0] e, input logic [10:0] n);
    @(posedge i_mclk);
    o_tok <= '{vld: 1'b1, kind: k, ep: e, len: n};
    @(posedge i_mclk);
    o_tok <= '{vld: 1'b0, kind: k, ep: 4'h2, len: ~n};
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] cfg; logic [10:0] lsz;} usbepm_row_s;
  localparam logic [2:0] SEND = 3'h4;
  localparam logic [2:0] STORE = 3'h2;
  localparam logic [2:0] NAK = 3'h1;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_usb_reset = 1'b0;
  usbepm_pkg::usbepm_wbreq_s i_wb = '0;
  usbepm_pkg::usbepm_tok_s i_tok;
  usbepm_pkg::usbepm_rsp_s o_rsp;
  logic o_wb_ack;
  logic [31:0] o_wb_dat;
  logic [15:0] o_ep_events;
  logic [3:0] o_dma_ep;
  logic o_dma_active;
  logic o_dma_write;
  logic [31:0] rd;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  usbepm_row_s rows [23] = '{
    '{8'h80, 11'h008}, '{8'h81, 11'h010}, '{8'h82, 11'h020}, '{8'h83, 11'h040}, '{8'h84, 11'h000},
    '{8'h90, 11'h010}, '{8'h91, 11'h020}, '{8'h92, 11'h030}, '{8'h93, 11'h040}, '{8'h94, 11'h060},
    '{8'h95, 11'h080}, '{8'h96, 11'h0A0}, '{8'h97, 11'h0C0}, '{8'h98, 11'h100}, '{8'h99, 11'h140},
    '{8'h9A, 11'h180}, '{8'h9B, 11'h200}, '{8'h9C, 11'h280}, '{8'h9D, 11'h300}, '{8'h9E, 11'h380},
    '{8'h9F, 11'h3FF}, '{8'h13, 11'h000}, '{8'hC3, 11'h040}};
  usbepm_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_usb_reset(i_usb_reset), .i_wb(i_wb),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_tok(i_tok), .o_rsp(o_rsp), .o_ep_events(o_ep_events),
    .o_dma_ep(o_dma_ep), .o_dma_active(o_dma_active), .o_dma_write(o_dma_write));
  usbepm_host host (.i_mclk(i_mclk), .o_tok(i_tok));
  // ----
  // Clock, timeout, tasks
  // ----
  initial forever #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge i_mclk);
    i_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do
    begin
      @(posedge i_mclk);
    end
    while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    i_wb <= '0;
  endtask
  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    cmp(rd, exp);
  endtask
  task automatic tok(input usbepm_pkg::usbepm_tok_e k, input logic [3:0] e, input logic [10:0] n, input logic [2:0] x);
    host.send_tok(k, e, n);
    @(negedge i_mclk);
    cmp({29'h0, o_rsp.send, o_rsp.store, o_rsp.nak}, {29'h0, x});
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rdchk(8'h04, 32'h0000_00A3);
    rdchk(8'h8C, 32'h0000_0080);
    rdchk(8'hFC, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
      wb(1'b1, 8'(i * 4), 32'h0000_0000);
    rdchk(8'h00, 32'h0000_0083);
    foreach (rows[i])
    begin
      wb(1'b1, 8'h08, {24'h0, rows[i].cfg});
      rdchk(8'h8C, {17'h0, 15'h0080 + (15'(rows[i].lsz) << rows[i].cfg[6])});
      if (rows[i].cfg[7])
        cmp({21'h0, o_rsp.maxpkt}, {21'h0, rows[i].lsz});
    end
    wb(1'b1, 8'h08, 32'h0000_0083);
    wb(1'b1, 8'h0C, 32'h0000_00A3);
    tok(usbepm_pkg::TOK_IN, 4'h3, 11'h000, NAK);
    tok(usbepm_pkg::TOK_OUT, 4'h3, 11'h008, NAK);
    wb(1'b1, 8'h88, 32'h0000_0023);
    tok(usbepm_pkg::TOK_IN, 4'h3, 11'h000, SEND);
    cmp({16'h0, o_ep_events}, 32'h0000_0008);
    rdchk(8'h4C, 32'h0000_0001);
    cmp({16'h0, o_ep_events}, 32'h0000_0000);
    tok(usbepm_pkg::TOK_OUT, 4'h2, 11'h041, NAK);
    tok(usbepm_pkg::TOK_OUT, 4'h2, 11'h040, STORE);
    rdchk(8'h80, 32'h0000_0004);
    tok(usbepm_pkg::TOK_OUT, 4'h2, 11'h008, NAK);
    rdchk(8'h48, 32'h0000_0003);
    wb(1'b1, 8'h88, 32'h0000_0012);
    tok(usbepm_pkg::TOK_OUT, 4'h2, 11'h008, STORE);
    wb(1'b1, 8'h88, 32'h0000_0021);
    tok(usbepm_pkg::TOK_SETUP, 4'h0, 11'h008, STORE);
    rdchk(8'h40, 32'h0000_000B);
    tok(usbepm_pkg::TOK_IN, 4'h1, 11'h000, NAK);
    wb(1'b1, 8'h88, 32'h0000_0010);
    tok(usbepm_pkg::TOK_OUT, 4'h0, 11'h008, NAK);
    wb(1'b1, 8'h88, 32'h0000_0030);
    wb(1'b1, 8'h88, 32'h0000_0021);
    tok(usbepm_pkg::TOK_IN, 4'h1, 11'h000, NAK);
    wb(1'b1, 8'h88, 32'h0000_0031);
    wb(1'b1, 8'h88, 32'h0000_0021);
    tok(usbepm_pkg::TOK_IN, 4'h1, 11'h000, SEND);
    wb(1'b1, 8'h84, 32'h0000_0013);
    @(negedge i_mclk);
    cmp({26'h0, o_dma_active, o_dma_write, o_dma_ep}, 32'h0000_0033);
    wb(1'b1, 8'h84, 32'h0000_0011);
    @(negedge i_mclk);
    cmp({26'h0, o_dma_active, o_dma_write, o_dma_ep}, 32'h0000_0011);
    @(posedge i_mclk);
    i_usb_reset <= 1'b1;
    @(posedge i_mclk);
    i_usb_reset <= 1'b0;
    rdchk(8'h0C, 32'h0000_0000);
    rdchk(8'h04, 32'h0000_00A3);
    cmp({16'h0, o_ep_events}, 32'h0000_0000);
    wb(1'b1, 8'h08, 32'h0000_0083);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rdchk(8'h08, 32'h0000_0000);
    rdchk(8'h00, 32'h0000_0083);
    close_out();
  end
endmodule
`default_nettype wire
